// ---- tb/fault_src_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module fault_src_model (
	// clock
	input wire logic ref_clk_in,
	// commands from the bench
	input wire logic [3:0] code_in,
	input wire logic fire_in,
	input wire logic low_act_in,
	input wire logic curlim_set_in,
	// fault lines toward the generator
	output logic [3:0] cmp_out,
	output logic [3:0] shared_out,
	output logic [1:0] indep_out,
	output logic curlim_out
);
	// idle lines sit at the inactive level of the chosen polarity
	always @(posedge ref_clk_in) begin
		cmp_out <= {4{low_act_in}};
		shared_out <= {4{low_act_in}};
		indep_out <= {2{low_act_in}};
		curlim_out <= curlim_set_in;
		if (fire_in) begin
			case (code_in)
				4'h0, 4'h1, 4'h2, 4'h3: cmp_out[code_in[1:0]] <= ~low_act_in;
				4'h8, 4'h9, 4'hA, 4'hB: shared_out[code_in[1:0]] <= ~low_act_in;
				4'hD: indep_out[0] <= ~low_act_in;
				4'hF: indep_out[1] <= ~low_act_in;
				// reserved codes: every line fires, so none may be picked
				default: begin
					cmp_out <= {4{~low_act_in}};
					shared_out <= {4{~low_act_in}};
					indep_out <= {2{~low_act_in}};
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// ---- tb/smps_pwm_fault_blanking_gen_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pwm_map.svh"
module smps_pwm_fault_blanking_gen_tb;
	logic ref_clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [15:0] wdata = 16'h0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [15:0] rdata;
	logic [3:0] cmp, sh;
	logic [1:0] ind;
	logic cl, hi, lo, trg;
	logic [3:0] code = 4'h0;
	logic fire = 1'b0;
	logic lowact = 1'b0;
	logic clset = 1'b0;
	logic [15:0] h, l, b, t, r;
	int fails = 0;
	int check_count = 0;
	always #5 ref_clk_in = ~ref_clk_in;
	smps_pwm_gen dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.comparator_in(cmp), .shared_fault_in(sh), .indep_fault_in(ind), .curlim_in(cl),
		.high_output_pin_out(hi), .low_output_pin_out(lo), .trig_event_out(trg));
	fault_src_model src (.ref_clk_in(ref_clk_in), .code_in(code), .fire_in(fire),
		.low_act_in(lowact), .curlim_set_in(clset), .cmp_out(cmp), .shared_out(sh),
		.indep_out(ind), .curlim_out(cl));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
		@(posedge ref_clk_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge ref_clk_in);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [2:0] a, output logic [15:0] d);
		@(posedge ref_clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge ref_clk_in);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// counts high cycles of each pin, overlaps and trigger pulses
	task automatic sample(input int n);
		h = 16'h0000;
		l = 16'h0000;
		b = 16'h0000;
		t = 16'h0000;
		repeat (n) begin
			@(posedge ref_clk_in);
			#1;
			h += hi;
			l += lo;
			b += (hi & lo);
			t += trg;
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [15:0] rst_v [7];
		rst_v = '{`FAULT_CTRL_RST, `TRIG_CMP_RST, `BLANK_CTRL_RST, `PERIOD_RST,
			`DUTY_RST, `PHASE_RST, `MODE_RST};
		for (int i = 0; i < 7; i++) begin
			rd_reg(3'(i), r);
			chk("reset value", rst_v[i], r);
		end
		wr_reg(`REG_TRIG_CMP, 16'hFFFF);
		rd_reg(`REG_TRIG_CMP, r);
		chk("trigger compare", 16'hFFF8, r);
		wr_reg(`REG_BLANK_CTRL, 16'hFFFF);
		rd_reg(`REG_BLANK_CTRL, r);
		chk("blanking ctrl", 16'hFFF8, r);
		wr_reg(`REG_BLANK_CTRL, 16'h0000);
		wr_reg(`REG_TRIG_CMP, 16'h0010);
		wr_reg(`REG_PERIOD, 16'h0009);
		wr_reg(`REG_DUTY, 16'h0003);
	endtask
	// period 9, duty 3: 20 cycles hold two whole pwm cycles of four high counts
	task automatic t_modes();
		logic [15:0] m [5];
		logic [15:0] eh [5];
		logic [15:0] el [5];
		m = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004};
		eh = '{16'h0008, 16'h0008, 16'h0004, 16'h0008, 16'h0008};
		el = '{16'h0000, 16'h000C, 16'h0004, 16'h0000, 16'h000C};
		for (int i = 0; i < 5; i++) begin
			wr_reg(`REG_MODE, m[i]);
			repeat (12) @(posedge ref_clk_in);
			sample(20);
			chk("high count", eh[i], h);
			chk("low count", el[i], l);
			chk("overlap", 16'h0000, b);
			chk("trigger", 16'h0002, t);
		end
		wr_reg(`REG_PHASE, 16'h0002);
		wr_reg(`REG_MODE, 16'h0003);
		repeat (12) @(posedge ref_clk_in);
		sample(16);
		chk("phase high", 16'h0004, h);
		wr_reg(`REG_PHASE, 16'h0000);
		wr_reg(`REG_MODE, 16'h0010);
	endtask
	task automatic do_fault(input logic [3:0] c, input logic p, input logic [1:0] md,
		input logic ovr);
		@(posedge ref_clk_in);
		code <= c;
		lowact <= p;
		repeat (5) @(posedge ref_clk_in);
		wr_reg(`REG_FAULT_CTRL, {9'h000, c, p, md});
		@(posedge ref_clk_in);
		fire <= 1'b1;
		repeat (6) @(posedge ref_clk_in);
		sample(4);
		chk("override low", ovr ? 16'h0004 : 16'h0000, l);
		if (ovr) chk("override high", 16'h0000, h);
		@(posedge ref_clk_in);
		fire <= 1'b0;
		repeat (25) @(posedge ref_clk_in);
		sample(10);
		chk("resumed low", 16'h0000, l);
		wr_reg(`REG_FAULT_CTRL, `FAULT_CTRL_RST);
	endtask
	task automatic t_faults();
		logic [3:0] codes [10];
		codes = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB, 4'hD, 4'hF};
		foreach (codes[i]) do_fault(codes[i], 1'b0, `FMOD_OVERRIDE, 1'b1);
		do_fault(4'h4, 1'b0, `FMOD_OVERRIDE, 1'b0);
		do_fault(4'hE, 1'b0, `FMOD_OVERRIDE, 1'b0);
		do_fault(4'h9, 1'b1, `FMOD_OVERRIDE, 1'b1);
		do_fault(4'hF, 1'b1, `FMOD_OVERRIDE, 1'b1);
		do_fault(4'h9, 1'b0, `FMOD_OFF, 1'b0);
	endtask
	task automatic t_blank();
		wr_reg(`REG_BLANK_CTRL, 16'h8FF8);
		wr_reg(`REG_FAULT_CTRL, 16'h0001);
		// let a high rise open the window before the fault can latch
		repeat (12) @(posedge ref_clk_in);
		@(posedge ref_clk_in);
		code <= 4'h0;
		clset <= 1'b1;
		fire <= 1'b1;
		repeat (15) @(posedge ref_clk_in);
		sample(4);
		chk("blanked fault", 16'h0000, l);
		rd_reg(`REG_STATUS, r);
		chk("blank status", 16'h0002, r & 16'h000A);
		wr_reg(`REG_BLANK_CTRL, 16'h83F8);
		repeat (6) @(posedge ref_clk_in);
		sample(4);
		chk("unblanked fault", 16'h0004, l);
		rd_reg(`REG_STATUS, r);
		chk("limit status", 16'h0008, r & 16'h0008);
		@(posedge ref_clk_in);
		fire <= 1'b0;
		clset <= 1'b0;
		repeat (25) @(posedge ref_clk_in);
		wr_reg(`REG_BLANK_CTRL, 16'h0BF8);
		repeat (120) @(posedge ref_clk_in);
		@(posedge ref_clk_in);
		fire <= 1'b1;
		repeat (6) @(posedge ref_clk_in);
		sample(4);
		chk("edges ignored", 16'h0004, l);
		@(posedge ref_clk_in);
		fire <= 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		fails++;
		final_report();
	end
	initial begin
		repeat (19) @(posedge ref_clk_in);
		#1;
		chk("outputs in reset", 16'h0000, {13'h0000, hi, lo, trg});
		@(posedge ref_clk_in);
		rst_in <= 1'b0;
		t_regs();
		t_modes();
		t_faults();
		t_blank();
		final_report();
	end
endmodule
`default_nettype wire

// ---- verilog/blank_if.sv ----
`timescale 1ns/100ps
`default_nettype none
interface blank_if #(parameter int CNT_W = 8);
	logic start;
	logic [CNT_W-1:0] cycles;
	logic active;
	modport ctrl(output start, output cycles, input active);
	modport timer(input start, input cycles, output active);
endinterface
`default_nettype wire

// ---- verilog/blank_timer.sv ----
`timescale 1ns/100ps
`default_nettype none
module blank_timer #(
	parameter int CNT_W = 8
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// control side
	blank_if.timer bus
);
	logic [CNT_W-1:0] cnt_q;

	if (CNT_W < 7 || CNT_W > 16) begin : g_bad_w
		$error("blank_timer CNT_W must lie in 7..16");
	end

	// a new enabled edge restarts the window rather than extending it
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			cnt_q <= '0;
		end else if (bus.start && bus.cycles != '0) begin
			cnt_q <= bus.cycles;
		end else if (cnt_q != '0) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end

	assign bus.active = (cnt_q != '0);

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_in);

	blank_load_a: assert property (bus.start && bus.cycles != '0 |=> cnt_q == $past(bus.cycles))
		else $error("blanking window did not load its length");
	blank_end_a: assert property (!bus.start && cnt_q == 1 |=> !bus.active)
		else $error("blanking window overran its length");
endmodule
`default_nettype wire

// ---- verilog/pwm_map.svh ----
`ifndef PWM_MAP_SVH
`define PWM_MAP_SVH

// register indices on the plain register port
`define REG_FAULT_CTRL 3'h0
`define REG_TRIG_CMP 3'h1
`define REG_BLANK_CTRL 3'h2
`define REG_PERIOD 3'h3
`define REG_DUTY 3'h4
`define REG_PHASE 3'h5
`define REG_MODE 3'h6
`define REG_STATUS 3'h7

// reset values
`define FAULT_CTRL_RST 16'h0003
`define TRIG_CMP_RST 16'h0000
`define BLANK_CTRL_RST 16'h0000
`define PERIOD_RST 16'h0063
`define DUTY_RST 16'h0031
`define PHASE_RST 16'h0000
`define MODE_RST 16'h0000

// fault control fields
`define FSRC_MSB 6
`define FSRC_LSB 3
`define FPOL_BIT 2
`define FMOD_MSB 1
`define FMOD_LSB 0
`define FMOD_OVERRIDE 2'h1
`define FMOD_OFF 2'h3

// fault source codes
`define FSRC_CMP1 4'h0
`define FSRC_CMP4 4'h3
`define FSRC_SH1 4'h8
`define FSRC_SH4 4'hB
`define FSRC_IND2 4'hD
`define FSRC_IND4 4'hF

// trigger compare and blanking fields
`define TRIGGER_COMPARE_FIELD_MSB 15
`define TRIGGER_COMPARE_FIELD_LSB 3
`define BLK_HR_BIT 15
`define BLK_HF_BIT 14
`define BLK_LR_BIT 13
`define BLK_LF_BIT 12
`define BLK_FLT_BIT 11
`define BLK_CL_BIT 10
`define BLK_DUR_MSB 9
`define BLK_DUR_LSB 3

// mode register fields and codes
`define MODE_MSB 2
`define MODE_LSB 0
`define FDAT_HIGH_BIT 5
`define FDAT_LOW_BIT 4
`define MODE_EDGE 3'h0
`define MODE_COMPL 3'h1
`define MODE_PUSH 3'h2
`define MODE_MULTI 3'h3
`define MODE_VARPH 3'h4

// timing
`define BLANK_STEP_NS 8
`define CLK_PERIOD_NS 10

`endif

// ---- verilog/pwm_pkg.sv ----
package pwm_pkg;
	typedef enum logic [4:0] {
		MODE_EDGE_S = 5'b00001,
		MODE_COMPL_S = 5'b00010,
		MODE_PUSH_S = 5'b00100,
		MODE_MULTI_S = 5'b01000,
		MODE_VARPH_S = 5'b10000
	} mode_t;
endpackage

// ---- verilog/smps_pwm_gen.sv ----
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "pwm_map.svh"
// Overview of operation
// - codes 0000-0011 pick comparators one to four
// - codes 1000-1011 pick shared fault inputs
// - 1101, 1111 pick independent faults; rest reserved
// - polarity bit set means fault active low
// - fault mode 01 forces override data
// - fault mode 11 ignores fault; 00/10 reserved
// - trigger compare is 13 bits, low three zero
// - four enables pick edges starting blanking
// - fault blank enable masks fault during blanking
// - limit blank enable masks limit during blanking
// - blanking duration counts in 8 ns steps
// - edge mode asserts while count <= duty
// - output deasserts once count exceeds duty
// - count reaching period restarts the cycle
// - complementary mode drives low as inverse
// - push-pull alternates pulse between pins
// - multi-phase adds phase, output comes earlier
// - variable phase also gives complementary low
// - override holds until next cycle start
module smps_pwm_gen #(
	parameter int CNT_W = 13,
	parameter int BLANK_W = 8
) (
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic rst_in,
	// register port
	input wire logic [2:0] reg_addr_in,
	input wire logic [15:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [15:0] reg_rdata_out,
	// fault and current-limit pins
	input wire logic [3:0] comparator_in,
	input wire logic [3:0] shared_fault_in,
	input wire logic [1:0] indep_fault_in,
	input wire logic curlim_in,
	// switch outputs and trigger
	output logic high_output_pin_out,
	output logic low_output_pin_out,
	output logic trig_event_out
);
	if (CNT_W < 4 || CNT_W > 16) begin : g_bad_cnt
		$error("CNT_W must lie in 4..16");
	end

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [10:0] pins_w;
	logic [10:0] sync1_q;
	logic [10:0] sync2_q;

	assign pins_w = {curlim_in, indep_fault_in, shared_fault_in, comparator_in};

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			sync1_q <= 11'h000;
			sync2_q <= 11'h000;
		end else begin
			sync1_q <= pins_w;
			sync2_q <= sync1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// functions

	function automatic logic sel_fault(input logic [3:0] code, input logic [9:0] s);
		logic r;
		r = 1'b0;
		if (code <= `FSRC_CMP4) begin
			r = s[code[1:0]];
		end else if (code >= `FSRC_SH1 && code <= `FSRC_SH4) begin
			r = s[4 + code[1:0]];
		end else if (code == `FSRC_IND2) begin
			r = s[8];
		end else if (code == `FSRC_IND4) begin
			r = s[9];
		end
		return r;
	endfunction

	function automatic pwm_pkg::mode_t decode_mode(input logic [2:0] code);
		pwm_pkg::mode_t m;
		case (code)
			`MODE_COMPL: m = pwm_pkg::MODE_COMPL_S;
			`MODE_PUSH: m = pwm_pkg::MODE_PUSH_S;
			`MODE_MULTI: m = pwm_pkg::MODE_MULTI_S;
			`MODE_VARPH: m = pwm_pkg::MODE_VARPH_S;
			default: m = pwm_pkg::MODE_EDGE_S;
		endcase
		return m;
	endfunction

	// least time rounds up; a zero duration yields no window at all
	function automatic logic [BLANK_W-1:0] blank_cycles(input logic [6:0] dur);
		logic [15:0] ns;
		ns = 16'(dur) * 16'(`BLANK_STEP_NS);
		return BLANK_W'((ns + 16'(`CLK_PERIOD_NS - 1)) / 16'(`CLK_PERIOD_NS));
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// registers

	logic [15:0] fcl_q;
	logic [15:0] trig_q;
	logic [15:0] blank_q;
	logic [CNT_W-1:0] per_q;
	logic [CNT_W-1:0] duty_q;
	logic [CNT_W-1:0] phase_q;
	logic [2:0] mode_q;
	logic [1:0] fdat_q;
	// a literal cannot be part-selected, so the reset word gets a name first
	localparam logic [15:0] MODE_RST_C = `MODE_RST;

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			fcl_q <= `FAULT_CTRL_RST;
			trig_q <= `TRIG_CMP_RST;
			blank_q <= `BLANK_CTRL_RST;
			per_q <= CNT_W'(`PERIOD_RST);
			duty_q <= CNT_W'(`DUTY_RST);
			phase_q <= CNT_W'(`PHASE_RST);
			mode_q <= MODE_RST_C[`MODE_MSB:`MODE_LSB];
			fdat_q <= MODE_RST_C[`FDAT_HIGH_BIT:`FDAT_LOW_BIT];
		end else if (reg_wr_in) begin
			case (reg_addr_in)
				`REG_FAULT_CTRL: fcl_q <= reg_wdata_in;
				`REG_TRIG_CMP: trig_q <= {reg_wdata_in[15:3], 3'h0};
				`REG_BLANK_CTRL: blank_q <= {reg_wdata_in[15:3], 3'h0};
				`REG_PERIOD: per_q <= reg_wdata_in[CNT_W-1:0];
				`REG_DUTY: duty_q <= reg_wdata_in[CNT_W-1:0];
				`REG_PHASE: phase_q <= reg_wdata_in[CNT_W-1:0];
				`REG_MODE: begin
					mode_q <= reg_wdata_in[`MODE_MSB:`MODE_LSB];
					fdat_q <= reg_wdata_in[`FDAT_HIGH_BIT:`FDAT_LOW_BIT];
				end
				default: ;
			endcase
		end
	end

	logic [3:0] fault_source_select;
	logic fault_polarity;
	logic [1:0] fault_mode;
	logic high_rise_blank_trig;
	logic high_fall_blank_trig;
	logic low_rise_blank_trig;
	logic low_fall_blank_trig;
	logic fault_blank_enable;
	logic curlim_blank_enable;
	logic [6:0] blanking_duration;
	logic [12:0] trigger_compare_field;
	pwm_pkg::mode_t mode_w;

	assign fault_source_select = fcl_q[`FSRC_MSB:`FSRC_LSB];
	assign fault_polarity = fcl_q[`FPOL_BIT];
	assign fault_mode = fcl_q[`FMOD_MSB:`FMOD_LSB];
	assign high_rise_blank_trig = blank_q[`BLK_HR_BIT];
	assign high_fall_blank_trig = blank_q[`BLK_HF_BIT];
	assign low_rise_blank_trig = blank_q[`BLK_LR_BIT];
	assign low_fall_blank_trig = blank_q[`BLK_LF_BIT];
	assign fault_blank_enable = blank_q[`BLK_FLT_BIT];
	assign curlim_blank_enable = blank_q[`BLK_CL_BIT];
	assign blanking_duration = blank_q[`BLK_DUR_MSB:`BLK_DUR_LSB];
	assign trigger_compare_field = trig_q[`TRIGGER_COMPARE_FIELD_MSB:`TRIGGER_COMPARE_FIELD_LSB];
	assign mode_w = decode_mode(mode_q);

	////////////////////////////////////////////////////////////////////////////
	// time base

	logic [CNT_W-1:0] tmr_q;
	logic [CNT_W-1:0] start_w;
	logic wrap_w;
	logic phased_w;
	logic pp_q;

	assign wrap_w = (tmr_q >= per_q);
	assign phased_w = (mode_w == pwm_pkg::MODE_MULTI_S) || (mode_w == pwm_pkg::MODE_VARPH_S);
	// a phase beyond the period would never wrap cleanly, so it starts at zero
	assign start_w = (phased_w && phase_q <= per_q) ? phase_q : '0;

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			tmr_q <= '0;
		end else if (wrap_w) begin
			tmr_q <= start_w;
		end else begin
			tmr_q <= tmr_q + 1'b1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			pp_q <= 1'b0;
		end else if (wrap_w && mode_w == pwm_pkg::MODE_PUSH_S) begin
			pp_q <= ~pp_q;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			trig_event_out <= 1'b0;
		end else begin
			trig_event_out <= (16'(tmr_q) == 16'(trigger_compare_field));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// fault qualification and override

	blank_if #(.CNT_W(BLANK_W)) blk ();
	logic fault_sel_w;
	logic fault_act_w;
	logic fault_ok_w;
	logic curlim_ok_w;
	logic ovr_set_w;
	logic ovr_q;

	assign fault_sel_w = sel_fault(fault_source_select, sync2_q[9:0]);
	assign fault_act_w = fault_sel_w ^ fault_polarity;
	assign fault_ok_w = fault_act_w && !(fault_blank_enable && blk.active);
	assign curlim_ok_w = sync2_q[10] && !(curlim_blank_enable && blk.active);
	// reserved modes 00 and 10 behave as disabled
	assign ovr_set_w = (fault_mode == `FMOD_OVERRIDE) && fault_ok_w;

	// a fault in the wrap cycle itself still latches: set beats clear
	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			ovr_q <= 1'b0;
		end else begin
			ovr_q <= ovr_set_w || (ovr_q && !wrap_w);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output generation

	logic raw_w;
	logic high_d;
	logic low_d;

	assign raw_w = (tmr_q <= duty_q);

	always_comb begin
		high_d = raw_w;
		low_d = 1'b0;
		case (mode_w)
			pwm_pkg::MODE_EDGE_S: low_d = 1'b0;
			pwm_pkg::MODE_COMPL_S: low_d = ~raw_w;
			pwm_pkg::MODE_PUSH_S: begin
				high_d = raw_w && !pp_q;
				low_d = raw_w && pp_q;
			end
			pwm_pkg::MODE_MULTI_S: low_d = 1'b0;
			pwm_pkg::MODE_VARPH_S: low_d = ~raw_w;
			default: low_d = 1'b0;
		endcase
		if (ovr_q) begin
			high_d = fdat_q[1];
			low_d = fdat_q[0];
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			high_output_pin_out <= 1'b0;
			low_output_pin_out <= 1'b0;
		end else begin
			high_output_pin_out <= high_d;
			low_output_pin_out <= low_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// blanking start: edges are taken from the next pin values so the window
	// opens on the same edge that moves the pin

	assign blk.start = (high_rise_blank_trig && high_d && !high_output_pin_out)
		|| (high_fall_blank_trig && !high_d && high_output_pin_out)
		|| (low_rise_blank_trig && low_d && !low_output_pin_out)
		|| (low_fall_blank_trig && !low_d && low_output_pin_out);
	assign blk.cycles = blank_cycles(blanking_duration);

	blank_timer #(.CNT_W(BLANK_W)) u_blank (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.bus(blk)
	);

	////////////////////////////////////////////////////////////////////////////
	// read port

	logic [15:0] status_w;

	assign status_w = {9'h000, low_output_pin_out, high_output_pin_out, pp_q,
		curlim_ok_w, fault_ok_w, blk.active, ovr_q};

	always_ff @(posedge ref_clk_in) begin
		if (rst_in) begin
			reg_rdata_out <= 16'h0000;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				`REG_FAULT_CTRL: reg_rdata_out <= fcl_q;
				`REG_TRIG_CMP: reg_rdata_out <= trig_q;
				`REG_BLANK_CTRL: reg_rdata_out <= blank_q;
				`REG_PERIOD: reg_rdata_out <= 16'(per_q);
				`REG_DUTY: reg_rdata_out <= 16'(duty_q);
				`REG_PHASE: reg_rdata_out <= 16'(phase_q);
				`REG_MODE: reg_rdata_out <= {10'h000, fdat_q, 1'b0, mode_q};
				`REG_STATUS: reg_rdata_out <= status_w;
				default: reg_rdata_out <= 16'h0000;
			endcase
		end else begin
			reg_rdata_out <= 16'h0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge ref_clk_in);
	endclocking
	default disable iff (rst_in);

	cmp_route_a: assert property (fault_source_select == `FSRC_CMP1 && sync2_q[0]
		&& !fault_polarity && fault_mode == `FMOD_OVERRIDE && !blk.active |=> ovr_q)
		else $error("comparator one fault did not override");
	shared_route_a: assert property (fault_source_select == `FSRC_SH4 && sync2_q[7]
		&& !fault_polarity && fault_mode == `FMOD_OVERRIDE && !blk.active |=> ovr_q)
		else $error("shared fault four did not override");
	reserved_src_a: assert property (fault_source_select == 4'h5 |-> !fault_sel_w)
		else $error("reserved fault source selected a pin");
	low_active_a: assert property (fault_polarity && fault_source_select == `FSRC_IND4
		&& !sync2_q[9] && fault_mode == `FMOD_OVERRIDE && !blk.active |=> ovr_q)
		else $error("low active fault was not honoured");
	override_pins_a: assert property (ovr_q |=> high_output_pin_out == $past(fdat_q[1])
		&& low_output_pin_out == $past(fdat_q[0]))
		else $error("override data not on the pins");
	fault_off_a: assert property (fault_mode == `FMOD_OFF && !ovr_q |=> !ovr_q)
		else $error("disabled fault mode still overrode");
	trig_low_zero_a: assert property (reg_rd_in && reg_addr_in == `REG_TRIG_CMP
		|=> reg_rdata_out[2:0] == 3'h0)
		else $error("trigger compare low bits not zero");
	blank_mask_a: assert property (blk.active && fault_blank_enable |-> !fault_ok_w)
		else $error("fault passed during blanking");
	limit_mask_a: assert property (blk.active && curlim_blank_enable |-> !curlim_ok_w)
		else $error("current limit passed during blanking");
	edge_high_a: assert property (!ovr_q && mode_w == pwm_pkg::MODE_EDGE_S
		&& tmr_q <= duty_q |=> high_output_pin_out)
		else $error("edge output low inside duty");
	edge_low_a: assert property (!ovr_q && mode_w == pwm_pkg::MODE_EDGE_S
		&& tmr_q > duty_q |=> !high_output_pin_out)
		else $error("edge output high past duty");
	wrap_zero_a: assert property (wrap_w && !phased_w |=> tmr_q == '0)
		else $error("counter did not restart from zero");
	compl_inv_a: assert property (!ovr_q && mode_w == pwm_pkg::MODE_COMPL_S
		|=> low_output_pin_out == !high_output_pin_out)
		else $error("complementary pins not inverse");
	push_excl_a: assert property (!ovr_q && mode_w == pwm_pkg::MODE_PUSH_S
		|=> !(high_output_pin_out && low_output_pin_out))
		else $error("push-pull drove both pins");
	phase_load_a: assert property (wrap_w && phased_w && phase_q <= per_q
		|=> tmr_q == $past(phase_q))
		else $error("phase not loaded at cycle start");
	varph_inv_a: assert property (!ovr_q && mode_w == pwm_pkg::MODE_VARPH_S
		|=> low_output_pin_out == !high_output_pin_out)
		else $error("variable phase low not inverse");
	override_hold_a: assert property (ovr_q && !wrap_w |=> ovr_q)
		else $error("override released before cycle start");
	blank_start_a: assert property (blk.start && blk.cycles != '0 |=> blk.active)
		else $error("enabled edge did not start blanking");

	fault_cover_c: cover property (!ovr_q ##1 ovr_q);
	push_cover_c: cover property (mode_w == pwm_pkg::MODE_PUSH_S && wrap_w ##1 !pp_q ##1 pp_q);
	blank_cover_c: cover property (blk.active && fault_act_w && fault_blank_enable);
	trig_cover_c: cover property (trig_event_out);
endmodule
`default_nettype wire
